// ==== dv/svd_analog_model.sv ====
// Behavioural model of the analog comparator and shared reference.
module svd_analog_model #(
    parameter int SETTLE = 20
) (
    // Digital side
    input  wire logic clk,
    input  wire logic power,
    // Bench commands
    input  wire logic trip_req,
    input  wire logic ref_off,
    // Analog outputs
    output logic      cmp_trip,
    output logic      ref_stable,
    output logic      bg_stable
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // Any power-off, ours or another user's, restarts the settle time.
    always @(posedge clk) begin
        if (!power || ref_off) cnt <= 0;
        else if (cnt < SETTLE) cnt <= cnt + 1;
    end
    // A switched-off reference loses its stable level at once; only the
    // settle time that follows is counted.
    assign ref_stable = (cnt == SETTLE) && power && !ref_off;
    assign bg_stable  = ref_stable;
    assign cmp_trip   = power & trip_req;
endmodule

// ==== dv/tb.sv ====
// Self-checking bench of the supply voltage detector control logic.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, trip = 0, roff = 0;
    logic        sleeping = 0, gie = 0;
    logic [1:0]  addr = '0;
    logic [7:0]  wdata = '0, rdata, d;
    logic        cmp, refs, bgs, pwr, ext, dir, irq, wake, tv;
    logic [15:0] tap;
    int          num_errors = 0, comparisons = 0;
    always #25 clk = ~clk;
    svd_top DUT (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .CMP_TRIP(cmp), .REF_STABLE(refs),
        .BG_STABLE(bgs), .ANALOG_POWER(pwr), .TAP_SELECT(tap),
        .EXT_INPUT_SELECT(ext), .DIR_RISING(dir), .SLEEPING(sleeping),
        .GLOBAL_IRQ_EN(gie), .IRQ(irq), .WAKE(wake), .TAKE_VECTOR(tv));
    svd_analog_model #(.SETTLE(20)) analog (.clk(clk), .power(pwr),
        .trip_req(trip), .ref_off(roff), .cmp_trip(cmp), .ref_stable(refs),
        .bg_stable(bgs));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(logic [1:0] a, logic [7:0] v);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask
    task automatic rd_reg(logic [1:0] a, logic [7:0] exp, string what);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        d = rdata;
        chk(d, exp, what);
    endtask
    task automatic wait_armed();
        for (int i = 0; i < 100; i++) begin
            repeat (2) @(posedge clk);
            #1;
            if (DUT.ANALOG_POWER === 1'b1 && refs === 1'b1) begin
                repeat (4) @(posedge clk);
                return;
            end
        end
        num_errors++;
        $display("MISMATCH %0t reference never settled", $time);
        complete_run();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        rd_reg(svd_pkg::ADDR_CONTROL, 8'h05, "ctrl reset");
        rd_reg(svd_pkg::ADDR_STATUS, 8'h00, "status reset");
        chk(pwr, 1'b0, "power at reset");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wr_reg(svd_pkg::ADDR_CONTROL, {i[0], 3'h0, i[3:0]});
            chk(tap, (i == 15) ? 16'h0 : 16'h1 << i, "tap");
            chk(ext, i == 15, "external select");
            chk(dir, i[0], "direction");
        end
        $display("test decode done");
        wr_reg(svd_pkg::ADDR_CONTROL, 8'h03);
        wr_reg(svd_pkg::ADDR_CONTROL, 8'h83);
        wr_reg(svd_pkg::ADDR_CONTROL, 8'hf3);
        chk(pwr, 1'b1, "power on");
        wr_reg(svd_pkg::ADDR_CLEAR, 8'h04);
        @(posedge clk);
        trip <= 1;
        rd_reg(svd_pkg::ADDR_CONTROL, 8'h93, "unsettled");
        @(posedge clk);
        trip <= 0;
        wait_armed();
        rd_reg(svd_pkg::ADDR_STATUS, 8'h00, "excursion dropped");
        rd_reg(svd_pkg::ADDR_CONTROL, 8'hf3, "settled");
        rd_reg(svd_pkg::ADDR_CLEAR, 8'h00, "clear reads zero");
        $display("test settle done");
        wr_reg(svd_pkg::ADDR_ENABLE, 8'h04);
        @(posedge clk);
        sleeping <= 1;
        trip <= 1;
        repeat (6) @(posedge clk);
        trip <= 0;
        rd_reg(svd_pkg::ADDR_STATUS, 8'h04, "event");
        chk({irq, wake, tv}, 3'b110, "irq wake no vector");
        @(posedge clk);
        gie <= 1;
        @(posedge clk);
        #1;
        chk(tv, 1'b1, "vector");
        wr_reg(svd_pkg::ADDR_ENABLE, 8'h00);
        chk(irq, 1'b0, "masked");
        wr_reg(svd_pkg::ADDR_CLEAR, 8'h04);
        rd_reg(svd_pkg::ADDR_STATUS, 8'h00, "cleared");
        chk(wake, 1'b0, "wake after clear");
        @(posedge clk);
        sleeping <= 0;
        $display("test event done");
        @(posedge clk);
        roff <= 1;
        trip <= 1;
        repeat (5) @(posedge clk);
        rd_reg(svd_pkg::ADDR_CONTROL, 8'h93, "ref lost");
        @(posedge clk);
        trip <= 0;
        roff <= 0;
        wait_armed();
        rd_reg(svd_pkg::ADDR_STATUS, 8'h00, "no event on resettle");
        wr_reg(svd_pkg::ADDR_CONTROL, 8'h83);
        chk(pwr, 1'b0, "power off");
        $display("test resettle done");
        complete_run();
    end
endmodule

// ==== hw/svd_pkg.sv ====
// Package of constants for the supply voltage detector control logic.
package svd_pkg;
    localparam int          DW              = 8;
    localparam int          AW              = 2;
    // Register offsets on the plain register port.
    localparam logic [1:0]  ADDR_CONTROL    = 2'h0;
    localparam logic [1:0]  ADDR_STATUS     = 2'h1;
    localparam logic [1:0]  ADDR_CLEAR      = 2'h2;
    localparam logic [1:0]  ADDR_ENABLE     = 2'h3;
    // Control register fields.
    localparam int          BIT_DIR         = 7;
    localparam int          BIT_BG_STABLE   = 6;
    localparam int          BIT_REF_STABLE  = 5;
    localparam int          BIT_ENABLE      = 4;
    localparam int          LEVEL_MSB       = 3;
    localparam int          LEVEL_W         = 4;
    localparam int          NUM_TAPS        = 16;
    localparam logic [3:0]  LEVEL_EXTERNAL  = 4'hf;
    localparam logic [7:0]  CONTROL_RESET   = 8'h05;
    localparam logic [7:0]  CONTROL_WMASK   = 8'h9f;
    // Event status, clear and enable layout.
    localparam int          BIT_DETECT      = 2;
    localparam logic [7:0]  EVENT_MASK      = 8'h04;
    typedef enum logic [2:0] {
        ST_OFF    = 3'b001,
        ST_SETTLE = 3'b010,
        ST_ARMED  = 3'b100
    } svd_state_e;
endpackage

// ==== hw/svd_top.sv ====
// Control, status and event logic of the supply voltage detector.
// Functional notes
// - Detector circuitry is powered only while detector_enable (bit 4) is set.
// - Reference stable flag low after enable until settled; no event before.
// - Direction bit 7: 0 watches falling to/below, 1 rising to/above.
// - Comparator trip in chosen direction sets detect_event_flag.
// - Level field bits 3:0 decoded to one of fifteen divider taps (values 0-14).
// - Level all ones routes external trip input to the comparator.
// - Settling comes from the analog stable indication, not a clock count.
// - Any reference power-off forces a fresh settle before detecting.
// - Excursions during settling are missed and latch no event.
// - Detector keeps working in sleep; a crossing sets the flag and wakes.
// - After a wake, vector only if global interrupts are enabled.
// - Device reset returns control to reset state, detector off.
//
// The strobed register port and the register addresses were left to the implementer.
module svd_top (
    // Clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    // Register port
    input  wire logic [1:0]           ADDR,
    input  wire logic [7:0]           WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [7:0]           RDATA,
    // Analog side
    input  wire logic                 CMP_TRIP,
    input  wire logic                 REF_STABLE,
    input  wire logic                 BG_STABLE,
    output logic                      ANALOG_POWER,
    output logic      [15:0]          TAP_SELECT,
    output logic                      EXT_INPUT_SELECT,
    output logic                      DIR_RISING,
    // Core interface
    input  wire logic                 SLEEPING,
    input  wire logic                 GLOBAL_IRQ_EN,
    output logic                      IRQ,
    output logic                      WAKE,
    output logic                      TAKE_VECTOR
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]       ctrl_q,   ctrl_d;
    logic [7:0]       stat_q,   stat_d;
    logic [7:0]       ien_q,    ien_d;
    logic [7:0]       rdata_q,  rdata_d;
    logic [2:0]       cmp_s1_q, cmp_s2_q;
    logic [2:0]       sync_d;
    svd_pkg::svd_state_e st_q, st_d;
    logic             trip_s, ref_s, bg_s, detect;
    logic             en;

    // Two-stage synchroniser for comparator and stable levels.
    assign sync_d = {CMP_TRIP, REF_STABLE, BG_STABLE};
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cmp_s1_q <= 3'h0;
            cmp_s2_q <= 3'h0;
        end else begin
            cmp_s1_q <= sync_d;
            cmp_s2_q <= cmp_s1_q;
        end
    end
    assign trip_s = cmp_s2_q[2];
    assign ref_s  = cmp_s2_q[1];
    assign bg_s   = cmp_s2_q[0];

    ////////////////////////////////////////////////////////////////////////
    // The analog comparator already encodes the direction; it reports a trip
    // when the supply has reached the tap in the selected direction.
    assign en               = ctrl_q[svd_pkg::BIT_ENABLE];
    assign ANALOG_POWER     = en;
    assign DIR_RISING       = ctrl_q[svd_pkg::BIT_DIR];
    assign EXT_INPUT_SELECT = ctrl_q[svd_pkg::LEVEL_MSB:0]
                              == svd_pkg::LEVEL_EXTERNAL;
    always_comb begin
        TAP_SELECT = 16'h0000;
        if (!EXT_INPUT_SELECT) begin
            TAP_SELECT[ctrl_q[svd_pkg::LEVEL_MSB:0]] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settle tracking: any drop of the stable level re-enters settling.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            svd_pkg::ST_OFF: begin
                if (en) begin
                    st_d = svd_pkg::ST_SETTLE;
                end
            end
            svd_pkg::ST_SETTLE: begin
                if (!en) begin
                    st_d = svd_pkg::ST_OFF;
                end else if (ref_s) begin
                    st_d = svd_pkg::ST_ARMED;
                end
            end
            svd_pkg::ST_ARMED: begin
                if (!en) begin
                    st_d = svd_pkg::ST_OFF;
                end else if (!ref_s) begin
                    st_d = svd_pkg::ST_SETTLE;
                end
            end
            default: st_d = svd_pkg::ST_OFF;
        endcase
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_q <= svd_pkg::ST_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    // Trips seen while settling are dropped, not held.
    assign detect = (st_q == svd_pkg::ST_ARMED) && ref_s && trip_s;

    ////////////////////////////////////////////////////////////////////////
    // Register file.
    always_comb begin
        ctrl_d  = ctrl_q;
        stat_d  = stat_q;
        ien_d   = ien_q;
        rdata_d = 8'h00;
        if (WR && ADDR == svd_pkg::ADDR_CONTROL) begin
            ctrl_d = WDATA & svd_pkg::CONTROL_WMASK;
        end
        if (WR && ADDR == svd_pkg::ADDR_ENABLE) begin
            ien_d = WDATA & svd_pkg::EVENT_MASK;
        end
        if (WR && ADDR == svd_pkg::ADDR_CLEAR) begin
            stat_d = stat_q & ~(WDATA & svd_pkg::EVENT_MASK);
        end
        // A crossing wins over a clear in the same cycle, so none is lost.
        if (detect) begin
            stat_d[svd_pkg::BIT_DETECT] = 1'b1;
        end
        if (RD) begin
            unique case (ADDR)
                svd_pkg::ADDR_CONTROL: begin
                    rdata_d = ctrl_q;
                    rdata_d[svd_pkg::BIT_REF_STABLE] =
                        (st_q == svd_pkg::ST_ARMED);
                    rdata_d[svd_pkg::BIT_BG_STABLE]  = bg_s;
                end
                svd_pkg::ADDR_STATUS: rdata_d = stat_q;
                svd_pkg::ADDR_ENABLE: rdata_d = ien_q;
                svd_pkg::ADDR_CLEAR:  rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_q  <= svd_pkg::CONTROL_RESET;
            stat_q  <= 8'h00;
            ien_q   <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q  <= ctrl_d;
            stat_q  <= stat_d;
            ien_q   <= ien_d;
            rdata_q <= rdata_d;
        end
    end
    // Read data stand one cycle after the strobe and idle at zero.
    assign RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and wake. Wake needs no clock gating beyond the flag itself.
    assign IRQ         = |(stat_q & ien_q);
    assign WAKE        = SLEEPING && stat_q[svd_pkg::BIT_DETECT];
    assign TAKE_VECTOR = IRQ && GLOBAL_IRQ_EN;

    ////////////////////////////////////////////////////////////////////////
    // Write path: control writes must reach the analog controls.
    a_power_follows_en: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (WR && ADDR == svd_pkg::ADDR_CONTROL)
        |=> ANALOG_POWER == $past(WDATA[svd_pkg::BIT_ENABLE]))
        else $error("Analog power does not follow enable.");
    a_dir_output: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (WR && ADDR == svd_pkg::ADDR_CONTROL)
        |=> DIR_RISING == $past(WDATA[svd_pkg::BIT_DIR]))
        else $error("Direction output mismatch.");
    a_tap_follows_level: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (WR && ADDR == svd_pkg::ADDR_CONTROL
         && WDATA[svd_pkg::LEVEL_MSB:0] != svd_pkg::LEVEL_EXTERNAL)
        |=> TAP_SELECT[$past(WDATA[svd_pkg::LEVEL_MSB:0])])
        else $error("Selected tap is not driven.");
    a_tap_onehot: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !EXT_INPUT_SELECT |-> $onehot(TAP_SELECT))
        else $error("Tap select is not one-hot.");
    a_ext_select: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (WR && ADDR == svd_pkg::ADDR_CONTROL
         && WDATA[svd_pkg::LEVEL_MSB:0] == svd_pkg::LEVEL_EXTERNAL)
        |=> EXT_INPUT_SELECT)
        else $error("All-ones level did not select the external input.");
    a_ext_route: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        EXT_INPUT_SELECT |-> TAP_SELECT == 16'h0000)
        else $error("External mode still drives a tap.");
    a_ro_bits: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        ctrl_q[svd_pkg::BIT_REF_STABLE] == 1'b0
        && ctrl_q[svd_pkg::BIT_BG_STABLE] == 1'b0)
        else $error("Read-only control bits were stored.");
    a_bg_status: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (RD && ADDR == svd_pkg::ADDR_CONTROL)
        |=> RDATA[svd_pkg::BIT_BG_STABLE] == $past(bg_s))
        else $error("Bandgap status does not read back live.");
    a_reset_off: assert property (
        @(posedge CORE_CLK)
        RST |=> !ANALOG_POWER && ctrl_q == svd_pkg::CONTROL_RESET)
        else $error("Reset did not turn the detector off.");

    // Settle tracking: no event until the reference is stable again.
    a_settle_entry: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == svd_pkg::ST_OFF && en) |=> st_q == svd_pkg::ST_SETTLE)
        else $error("Enable did not start settling.");
    a_off_when_disabled: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !en |=> st_q == svd_pkg::ST_OFF)
        else $error("Detector stays active while disabled.");
    a_no_early_event: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (st_q != svd_pkg::ST_ARMED) |=> !$rose(stat_q[svd_pkg::BIT_DETECT]))
        else $error("Detect flag rose before reference settled.");
    a_ref_bit_read: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (RD && ADDR == svd_pkg::ADDR_CONTROL && st_q != svd_pkg::ST_ARMED)
        |=> !RDATA[svd_pkg::BIT_REF_STABLE])
        else $error("Reference stable read high while settling.");
    a_arm_on_stable: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == svd_pkg::ST_SETTLE && en && ref_s)
        |=> st_q == svd_pkg::ST_ARMED)
        else $error("Stable reference did not arm the detector.");
    a_resettle_drop: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (st_q == svd_pkg::ST_ARMED && !ref_s && en)
        |=> st_q == svd_pkg::ST_SETTLE)
        else $error("Reference loss did not force resettle.");
    a_flag_needs_ref: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $rose(stat_q[svd_pkg::BIT_DETECT]) |-> $past(ref_s) && $past(trip_s))
        else $error("Detect flag set without a stable reference.");

    // Event flag, synchronisers and wake.
    a_trip_sets_flag: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        detect |=> stat_q[svd_pkg::BIT_DETECT])
        else $error("Trip did not set detect flag.");
    a_flag_sticky: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (stat_q[svd_pkg::BIT_DETECT]
         && !(WR && ADDR == svd_pkg::ADDR_CLEAR
              && WDATA[svd_pkg::BIT_DETECT]))
        |=> stat_q[svd_pkg::BIT_DETECT])
        else $error("Detect flag dropped without a clear.");
    a_flag_clear: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (WR && ADDR == svd_pkg::ADDR_CLEAR && WDATA[svd_pkg::BIT_DETECT]
         && !detect)
        |=> !stat_q[svd_pkg::BIT_DETECT])
        else $error("Clear did not drop the detect flag.");
    a_sync_delay: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $rose(REF_STABLE) ##1 REF_STABLE |=> ref_s)
        else $error("Stable level not seen after two stages.");
    a_trip_sync: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $rose(CMP_TRIP) ##1 CMP_TRIP |=> trip_s)
        else $error("Comparator level not seen after two stages.");
    a_wake_flag: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (SLEEPING && detect) |=> WAKE)
        else $error("Crossing in sleep gave no wake.");
    a_vector_gate: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        TAKE_VECTOR == (stat_q[svd_pkg::BIT_DETECT]
                        && ien_q[svd_pkg::BIT_DETECT] && GLOBAL_IRQ_EN))
        else $error("Vector taken against flag, enable or global gate.");

    c_armed_detect: cover property (@(posedge CORE_CLK) disable iff (RST)
        detect);
    c_resettle: cover property (@(posedge CORE_CLK) disable iff (RST)
        st_q == svd_pkg::ST_ARMED ##1 st_q == svd_pkg::ST_SETTLE);
    c_sleep_wake: cover property (@(posedge CORE_CLK) disable iff (RST)
        $rose(WAKE));
    c_external_mode: cover property (@(posedge CORE_CLK) disable iff (RST)
        EXT_INPUT_SELECT);
    c_excursion_dropped: cover property (@(posedge CORE_CLK)
        disable iff (RST) st_q == svd_pkg::ST_SETTLE && trip_s);
endmodule
